// [cgmr_regs.vh]
// register offsets, field positions, reset values and timing counts
`ifndef CGMR_REGS_VH
`define CGMR_REGS_VH
`define CGMR_OFS_GAIN_FIRST 8'h01
`define CGMR_OFS_GAIN_LAST  8'h08
`define CGMR_OFS_FINE       8'h09
`define CGMR_OFS_SILENCE    8'h0a
`define CGMR_OFS_SETUP1     8'h0b
`define CGMR_OFS_SETUP2     8'h0c
`define CGMR_RST_GAIN       8'hd2
`define CGMR_RST_FINE       8'h00
`define CGMR_RST_SILENCE    8'h00
`define CGMR_RST_SETUP1     8'h20
`define CGMR_RST_SETUP2     8'h0d
`define CGMR_BIT_PIN_GATE   5
`define CGMR_BIT_PIN_LEVEL  4
`define CGMR_UNITY_CODE     8'hd2
`define CGMR_GAIN_MIN       9'h024
`define CGMR_GAIN_MAX       9'h1fc
`define CGMR_ZC_NOW         2'b00
`define CGMR_ZC_DISCARD     2'b01
`define CGMR_ZC_FLUSH       2'b10
`define CGMR_CLK_KHZ        40000
`define CGMR_CYC_PER_MS     (`CGMR_CLK_KHZ / 1000 * 1000)
`endif

// [cgmr_channel_gain_mute_regs.v]
// register bank for per-channel gain, quarter steps, mutes and pairing
`timescale 1ns/10ps
`include "cgmr_regs.vh"
// Operation
// RULE1: eight 8-bit half-dB gain registers
// RULE2: code is twice dB plus 210
// RULE3: host rounds down, quarter via bit
// RULE4: out-of-range codes stored, output clamped
// RULE5: changes applied per zero-cross mode, time-out
// RULE6: quarter-step bit adds quarter dB
// RULE7: mute bit per channel, set mutes
// RULE8: pin gate enables external mute pin
// RULE9: polarity bit selects pin active level
// RULE10: paired channels follow lower channel registers
// RULE11: pair bits 3..0 tie 78,56,34,12
// RULE12: cleared pair bit gives independent channels
// RULE13: policy 00 now, 01 discard, 10 flush
// RULE14: time-out codes select 5..50 ms
// RULE15: mode 01 new change discards pending
// RULE16: mode 10 new change flushes pending
// RULE17: mute is bit OR gated synced pin
// RULE18: gain is code with quarter LSB, clamped
module cgmr_channel_gain_mute_regs #(
  parameter MS_CYCLES = `CGMR_CYC_PER_MS
) (
  input  wire        clk,
  input  wire        reset,
  input  wire        wr_en,
  input  wire [7:0]  wr_addr,
  input  wire [7:0]  wr_data,
  input  wire [7:0]  rd_addr,
  input  wire        silence_pin,
  input  wire [7:0]  zero_cross,
  output reg  [7:0]  rd_data,
  output reg  [71:0] gain_out,
  output reg  [7:0]  silence_out
);
  // time-out length in ms for each code
  function [5:0] tmo_ms;
    input [2:0] c;
    begin
      case (c)
        3'd0: tmo_ms = 6'd5;
        3'd1: tmo_ms = 6'd10;
        3'd2: tmo_ms = 6'd15;
        3'd3: tmo_ms = 6'd18;
        3'd4: tmo_ms = 6'd20;
        3'd5: tmo_ms = 6'd30;
        3'd6: tmo_ms = 6'd40;
        default: tmo_ms = 6'd50;
      endcase
    end
  endfunction
  // out-of-range codes stay legal, only the output is bounded
  // quarter-dB code with clamp to analog range
  function [8:0] clamp_gain;
    input [7:0] code;
    input       q;
    reg   [8:0] v;
    begin
      v = {code, q};
      if (v < `CGMR_GAIN_MIN)
        clamp_gain = `CGMR_GAIN_MIN;
      else if (v > `CGMR_GAIN_MAX)
        clamp_gain = `CGMR_GAIN_MAX;
      else
        clamp_gain = v;
    end
  endfunction
  // true for the eight per-channel gain offsets
  function is_gain_ofs;
    input [7:0] a;
    begin
      is_gain_ofs = (a >= `CGMR_OFS_GAIN_FIRST) && (a <= `CGMR_OFS_GAIN_LAST);
    end
  endfunction
  // channel index of a gain offset, offset 1 is channel 1
  function [2:0] gain_idx;
    input [7:0] a;
    begin
      gain_idx = a[2:0] - 3'd1;
    end
  endfunction

  // host-visible register storage and pin sync flops
  reg  [7:0]  gain_reg [0:7];
  reg  [7:0]  fine_step_bit_reg;
  reg  [7:0]  chan_silence_bit_reg;
  reg  [7:0]  setup1_reg;
  reg  [7:0]  setup2_reg;
  reg         pin_meta_reg;
  reg         pin_sync_reg;
  // per-channel targets and zero-cross state
  reg  [8:0]  target [0:7];
  reg  [8:0]  pend_reg [0:7];
  reg  [7:0]  pending_reg;
  reg  [21:0] tmo_cnt_reg [0:7];
  reg  [7:0]  silence_pre;
  wire [1:0]  zero_cross_policy = setup2_reg[1:0];
  wire [3:0]  pair_link = setup1_reg[3:0];
  // wait length in clock cycles for the selected code
  wire [21:0] tmo_limit = tmo_ms(setup2_reg[4:2]) * MS_CYCLES[21:0];
  // reserved policy code behaves as immediate
  wire        policy_now = (zero_cross_policy == `CGMR_ZC_NOW) || (zero_cross_policy == 2'b11);
  wire        pin_active;
  integer     i;
  integer     j;
  integer     k;

  // register writes and readback
  always @(posedge clk) begin
    if (reset) begin
      // gain codes start at unity, pin gate starts on
      for (i = 0; i < 8; i = i + 1)
        gain_reg[i] <= `CGMR_RST_GAIN; // see RULE1
      fine_step_bit_reg    <= `CGMR_RST_FINE; // see RULE6
      chan_silence_bit_reg <= `CGMR_RST_SILENCE; // see RULE7
      setup1_reg           <= `CGMR_RST_SETUP1;
      setup2_reg           <= `CGMR_RST_SETUP2;
      rd_data              <= 8'h00;
    end else begin
      // unmapped offsets fall through untouched
      if (wr_en) begin
        if (is_gain_ofs(wr_addr))
          gain_reg[gain_idx(wr_addr)] <= wr_data; // see RULE4
        if (wr_addr == `CGMR_OFS_FINE)
          fine_step_bit_reg <= wr_data;
        if (wr_addr == `CGMR_OFS_SILENCE)
          chan_silence_bit_reg <= wr_data;
        if (wr_addr == `CGMR_OFS_SETUP1)
          setup1_reg <= {2'b00, wr_data[5:0]}; // reserved bits read zero
        if (wr_addr == `CGMR_OFS_SETUP2)
          setup2_reg <= {3'b000, wr_data[4:0]};
      end
      // readback, one cycle behind rd_addr
      if (is_gain_ofs(rd_addr))
        rd_data <= gain_reg[gain_idx(rd_addr)];
      else if (rd_addr == `CGMR_OFS_FINE)
        rd_data <= fine_step_bit_reg;
      else if (rd_addr == `CGMR_OFS_SILENCE)
        rd_data <= chan_silence_bit_reg;
      else if (rd_addr == `CGMR_OFS_SETUP1)
        rd_data <= setup1_reg;
      else if (rd_addr == `CGMR_OFS_SETUP2)
        rd_data <= setup2_reg;
      else
        rd_data <= 8'h00;
    end
  end

  // two-stage sync of the external mute pin
  // flops reset to the idle high level, no false mute after reset
  always @(posedge clk) begin
    if (reset) begin
      pin_meta_reg <= 1'b1;
      pin_sync_reg <= 1'b1;
    end else begin
      pin_meta_reg <= silence_pin;
      pin_sync_reg <= pin_meta_reg; // see RULE17
    end
  end

  // gated, polarity-corrected pin
  assign pin_active = setup1_reg[`CGMR_BIT_PIN_GATE] & // see RULE8
    (pin_sync_reg == setup1_reg[`CGMR_BIT_PIN_LEVEL]); // see RULE9

  // select source channel per pairing, form targets
  always @* begin
    // odd channel of a linked pair copies its lower partner
    for (j = 0; j < 8; j = j + 1) begin
      if (j[0] && pair_link[j >> 1]) begin // see RULE10 see RULE11
        target[j]      = clamp_gain(gain_reg[j - 1], fine_step_bit_reg[j - 1]);
        silence_pre[j] = chan_silence_bit_reg[j - 1];
      end else begin // see RULE12
        target[j]      = clamp_gain(gain_reg[j], fine_step_bit_reg[j]); // see RULE18
        silence_pre[j] = chan_silence_bit_reg[j];
      end
    end
  end

  // per-channel zero-cross application and time-out
  always @(posedge clk) begin
    if (reset) begin
      for (k = 0; k < 8; k = k + 1) begin
        gain_out[k*9 +: 9] <= {`CGMR_UNITY_CODE, 1'b0}; // see RULE2
        pend_reg[k]        <= {`CGMR_UNITY_CODE, 1'b0};
        tmo_cnt_reg[k]     <= 22'd0;
      end
      pending_reg <= 8'h00;
      silence_out <= 8'h00;
    end else begin
      for (k = 0; k < 8; k = k + 1) begin
        // mute is never delayed by the zero-cross policy
        silence_out[k] <= silence_pre[k] | pin_active; // see RULE17
        if (policy_now) begin
          // immediate policy, nothing left pending
          gain_out[k*9 +: 9] <= target[k]; // see RULE13
          pending_reg[k]     <= 1'b0;
        end else if (target[k] != (pending_reg[k] ? pend_reg[k] : gain_out[k*9 +: 9])) begin
          // new change: flush or drop the older pending one
          if (pending_reg[k] && zero_cross_policy == `CGMR_ZC_FLUSH) begin
            gain_out[k*9 +: 9] <= pend_reg[k]; // see RULE16
          end
          pend_reg[k]    <= target[k]; // see RULE15
          pending_reg[k] <= 1'b1;
          tmo_cnt_reg[k] <= 22'd0; // see RULE5
        end else if (pending_reg[k]) begin
          // apply at a crossing or once the wait runs out
          if (zero_cross[k] || tmo_cnt_reg[k] + 22'd1 >= tmo_limit) begin // see RULE14
            gain_out[k*9 +: 9] <= pend_reg[k];
            pending_reg[k]     <= 1'b0;
          end else begin
            tmo_cnt_reg[k] <= tmo_cnt_reg[k] + 22'd1;
          end
        end
      end
    end
  end
endmodule // cgmr_channel_gain_mute_regs

// [cgmr_checker.sv]
// port assertions for the gain and mute register bank
`timescale 1ns/10ps
module cgmr_checker (
  input wire clk, input wire reset, input wire wr_en, input wire [7:0] wr_addr,
  input wire [7:0] wr_data, input wire [7:0] rd_addr, input wire [7:0] rd_data,
  input wire [71:0] gain_out, input wire [7:0] silence_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_reset_vals: assert property (disable iff (1'b0) reset |=> gain_out == {8{9'h1a4}}
    && rd_data == 8'h00) else $error("bad reset");
  a_mute_read: assert property (wr_en && wr_addr == 8'h0a ##1 !wr_en && rd_addr == 8'h0a
    |=> rd_data == $past(wr_data, 2)) else $error("bad readback");
  a_setup_read: assert property (wr_en && wr_addr == 8'h0b ##1 !wr_en && rd_addr == 8'h0b
    |=> rd_data == {2'b00, $past(wr_data[5:0], 2)}) else $error("bad setup");
  a_unmapped_zero: assert property (rd_addr == 8'h00 || rd_addr > 8'h0c
    |=> rd_data == 8'h00) else $error("bad unmapped");
  a_clamp_low: assert property (gain_out[8:0] >= 9'h024) else $error("low");
  a_clamp_high: assert property (gain_out[71:63] <= 9'h1fc) else $error("high");
  a_mute_bit: assert property (wr_en && wr_addr == 8'h0a && wr_data[0] ##1 !wr_en
    |=> silence_out[0]) else $error("mute lost");
  a_read_stable: assert property (!$past(wr_en) && !$past(reset) && $stable(rd_addr)
    |=> $stable(rd_data)) else $error("read moved");
  c_setup_two: cover property (wr_en && wr_addr == 8'h0c);
  c_all_muted: cover property (silence_out == 8'hff);
  c_top_gain: cover property (gain_out[8:0] == 9'h1fc);
endmodule // cgmr_checker
bind cgmr_channel_gain_mute_regs cgmr_checker cgmr_checker_i (.*);

// [cgmr_host_model.sv]
// host controller model issuing register writes
`timescale 1ns/10ps
module cgmr_host_model (
  input  wire       clk,
  output reg        wr_en,
  output reg  [7:0] wr_addr,
  output reg  [7:0] wr_data
);
  initial {wr_en, wr_addr, wr_data} = 17'h0_0000;
  // one-cycle strobe, data scrambled once released
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk); #1 {wr_en, wr_addr, wr_data} = {1'b1, a, d};
      @(posedge clk); #1 {wr_en, wr_data} = {1'b0, ~d};
    end
  endtask
endmodule // cgmr_host_model

// [channel_gain_mute_regs_tb.sv]
// self-checking bench for the gain and mute register bank
`timescale 1ns/10ps
module channel_gain_mute_regs_tb;
  reg clk, reset, silence_pin;
  reg [7:0] rd_addr, zero_cross, q, m, p, g [0:7];
  reg [31:0] s = 32'h0000_522e;
  wire wr_en;
  wire [7:0] wr_addr, wr_data, rd_data, silence_out;
  wire [71:0] gain_out;
  integer errors = 0, num_checks = 0, i, k, r;
  cgmr_host_model cgmr_host_model_i (.clk(clk), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data));
  cgmr_channel_gain_mute_regs #(.MS_CYCLES(2)) cgmr_channel_gain_mute_regs_i (.clk(clk),
    .reset(reset), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr),
    .silence_pin(silence_pin), .zero_cross(zero_cross), .rd_data(rd_data),
    .gain_out(gain_out), .silence_out(silence_out));
  function [7:0] rnd(input x);
    begin s = s ^ (s << 13); s = s ^ (s >> 17); s = s ^ (s << 5); rnd = s[7:0]; end
  endfunction
  // expected clamped gain and pair source channel
  function [8:0] eg(input [8:0] c);
    eg = c < 9'h024 ? 9'h024 : (c > 9'h1fc ? 9'h1fc : c);
  endfunction
  function integer sr(input integer n);
    sr = (n % 2 && p[n / 2]) ? n - 1 : n;
  endfunction
  task chk(input [71:0] seen, input [71:0] want);
    begin
      num_checks = num_checks + 1;
      if (seen !== want) begin
        errors = errors + 1;
        $display("CHECK FAILED %0t %h %h", $time, seen, want);
      end
    end
  endtask
  task end_of_test;
    begin
      if (errors == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  task rd(input [7:0] a, input [7:0] w);
    begin @(posedge clk); #1 rd_addr = a; repeat (2) @(posedge clk); #1 chk(rd_data, w); end
  endtask
  task eff;
    begin
      repeat (4) @(posedge clk); #1;
      for (k = 0; k < 8; k = k + 1) begin
        chk(gain_out[9*k +: 9], eg({g[sr(k)], q[sr(k)]}));
        chk(silence_out[k], m[sr(k)]);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    cgmr_host_model_i.wr(a, d);
  endtask
  initial begin clk = 0; forever #12.5 clk = ~clk; end
  initial begin #100000; errors = errors + 1; end_of_test; end
  initial begin
    {reset, silence_pin, rd_addr, zero_cross, p, q, m} = {2'b11, 40'h0};
    for (i = 0; i < 8; i = i + 1) g[i] = 8'hd2;
    repeat (3) @(posedge clk); #1 reset = 0;
    rd(8'h01, 8'hd2); rd(8'h0b, 8'h20); rd(8'h0c, 8'h0d); rd(8'h0f, 8'h00);
    eff;
    wr(8'h0c, 8'h00); wr(8'h20, 8'hff); rd(8'h20, 8'h00);
    // random rounds, first round at both clamp ends
    for (r = 0; r < 6; r = r + 1) begin
      for (i = 0; i < 8; i = i + 1) begin
        g[i] = r ? rnd(0) : (i < 4 ? 8'h00 : 8'hff);
        wr(i + 1, g[i]);
      end
      q = r ? rnd(0) : 8'hff; m = rnd(0); p = rnd(0) & 8'h0f;
      wr(8'h09, q); wr(8'h0a, m); wr(8'h0b, 8'h20 | p);
      eff; rd(8'h0a, m);
    end
    // pin active low, then high polarity, then gate off
    silence_pin = 0; repeat (5) @(posedge clk); #1 chk(silence_out, 8'hff);
    p = 0; wr(8'h0b, 8'h30); eff; wr(8'h0b, 8'h00); eff;
    // zero-crossing mode with 10-cycle time-out
    wr(8'h0c, 8'h01); wr(8'h01, 8'h80); repeat (4) @(posedge clk); #1 chk(gain_out[8:0], eg({g[0], q[0]}));
    zero_cross = 8'hff; @(posedge clk); #1 zero_cross = 0;
    g[0] = 8'h80; repeat (3) @(posedge clk); #1 chk(gain_out[8:0], eg({g[0], q[0]}));
    g[0] = 8'h90; wr(8'h01, g[0]); repeat (20) @(posedge clk); #1 chk(gain_out[8:0], eg({g[0], q[0]}));
    // flush mode: older pending change goes out when a newer one arrives
    wr(8'h0c, 8'h02); wr(8'h01, 8'ha0); wr(8'h01, 8'hb0);
    @(posedge clk); #1 chk(gain_out[8:0], eg({8'ha0, q[0]}));
    g[0] = 8'hb0; repeat (20) @(posedge clk); #1 chk(gain_out[8:0], eg({g[0], q[0]}));
    end_of_test;
  end
endmodule // channel_gain_mute_regs_tb
